// ---- hw/strap_map.svh ----
// offsets, field positions, reset values and timing counts of the strap
// and host pin block; included by the role memory and the pin block, definitions only
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH

`define CLK_FREQ_HZ 20000000
`define STRAP_HOLD_MS 55
`define STRAP_HOLD_CYC ((`STRAP_HOLD_MS * `CLK_FREQ_HZ) / 1000)
`define STRAP_CNT_W 21
`define STRAP_SAMPLE_CYC 21'h000002
`define GPIO_COUNT 12
`define GPIO_MODE_PIN 3
`define GPIO_RATE_LO_PIN 0
`define GPIO_RATE_HI_PIN 1
`define I2C_STRAP_LEVEL 1'b1
`define STATUS_ADDR 7'h00
`define STATUS_READY_BIT 7
`define STATUS_MODE_BIT 2
`define CFG_BASE_ADDR 7'h01
`define CFG_LAST_ADDR 7'h0C
`define ROLE_RST 2'h0
`define SPI_CMD_LAST 4'h7
`define SPI_FRAME_LAST 4'hF
`define SPI_READ_BIT 7

`endif

// ---- hw/strap_pkg.sv ----
// types shared by the strap and host pin block and its role memory
// assumes strap_map.svh is on the include path
package strap_pkg;
	typedef enum logic [1:0] {
		ST_STRAP = 2'b01,
		ST_RUN = 2'b10
	} phase_t;
	typedef enum logic [1:0] {
		ROLE_IN = 2'h0,
		ROLE_OUT = 2'h1,
		ROLE_IRQ = 2'h2
	} gpio_role_t;
	typedef enum logic {
		HOST_SPI = 1'b0,
		HOST_I2C = 1'b1
	} host_mode_t;
	typedef logic [1:0] rate_sel_t;
endpackage : strap_pkg

// ---- hw/role_mem_if.sv ----
// carrier between the pin block and its role memory
// one write port and one registered read port, both on clk
`timescale 1ns/1ps
interface role_mem_if;
	logic wr_en;
	logic [3:0] wr_addr;
	logic [1:0] wr_data;
	logic [3:0] rd_addr;
	logic [1:0] rd_data;
	modport owner (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data);
endinterface : role_mem_if

// ---- hw/gpio_role_mem.sv ----
// sixteen-entry store of general purpose pin roles
// assumes one clock; read data come out of a register one cycle later
`timescale 1ns/1ps
`include "strap_map.svh"
module gpio_role_mem (
	input wire logic clk,
	input wire logic nrst,
	role_mem_if.mem port
);
	import strap_pkg::*;

	logic [1:0] store_r [0:15];
	logic [1:0] rd_r;

	// every entry comes out of reset as a plain input role
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_entry
			always_ff @(posedge clk) begin
				if (!nrst)
					store_r[g] <= `ROLE_RST;
				else if (port.wr_en && port.wr_addr == 4'(g))
					store_r[g] <= port.wr_data;
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!nrst)
			rd_r <= `ROLE_RST;
		else
			rd_r <= store_r[port.rd_addr];
	end

	assign port.rd_data = rd_r;
endmodule : gpio_role_mem

// ---- hw/reset_strap_host_pin_select.sv ----
// strap capture after reset, general purpose pin roles and the shared
// host pin roles (spi or i2c); the spi shifter runs on host_clk.
// assumes pins arrive raw and the far side keeps straps for the hold time.
//
// Contract
// RULE1 - each general purpose pin is driven or sampled per its stored role
// RULE2 - a pin may be interrupt output flagging any device status change
// RULE3 - after reset pin 3 level chooses i2c or spi host mode
// RULE4 - after reset pins 1 and 0 give the master clock rate
// RULE5 - far side holds pins 0, 1, 3 at strap levels for 55 ms
// RULE6 - far side holds pins 4 and 5 low for 55 ms
// RULE7 - serial clock pin is spi clock, or i2c clock line in i2c mode
// RULE8 - serial input carries command, address, write data; i2c data line
// RULE9 - serial output drives read data bits only, in spi mode
// RULE10 - in i2c mode serial output is an input giving address bit
// RULE11 - chip select frames spi low; in i2c mode it is address bit
// RULE12 - host waits 55 ms or ready bit 7 of address 0x00
// RULE13 - straps caught once after reset and held until next reset
`timescale 1ns/1ps
`include "strap_map.svh"
module reset_strap_host_pin_select #(
	parameter int unsigned STRAP_HOLD_CYCLES = `STRAP_HOLD_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic host_clk,
	input wire logic [11:0] gpio_in,
	output logic [11:0] gpio_out,
	output logic [11:0] gpio_oe,
	input wire logic [11:0] proc_gpio_out,
	output logic [11:0] proc_gpio_in,
	input wire logic [7:0] dev_status,
	input wire logic irq_clear,
	output logic irq_pending,
	input wire logic host_select_addr_sel_lo_n,
	input wire logic host_serial_in,
	output logic host_serial_in_out,
	output logic host_serial_in_oe,
	input wire logic host_serial_out_addr_sel_hi_in,
	output logic host_serial_out_addr_sel_hi_out,
	output logic host_serial_out_addr_sel_hi_oe,
	input wire logic scl_in,
	output logic scl_sampled,
	output logic sda_sampled,
	input wire logic sda_pull_low,
	output strap_pkg::host_mode_t host_mode,
	output strap_pkg::rate_sel_t clk_rate_sel,
	output logic [1:0] i2c_addr_sel,
	output logic regs_ready
);
	import strap_pkg::*;

	// ---------------- clk domain ----------------
	phase_t phase_r, phase_nxt;
	logic [`STRAP_CNT_W-1:0] cnt_r;
	logic [11:0] gpio_s1_r, gpio_s2_r;
	logic [1:0] pin_s1_r, pin_s2_r, i2c_s1_r, i2c_s2_r;
	logic cs_s1_r, cs_s2_r, cs_s3_r, wv_s1_r, wv_s2_r;
	logic [7:0] stat_prev_r;
	logic irq_r;
	logic [3:0] scan_r, scan_d_r;
	logic [1:0] role_r [0:11];
	logic [23:0] role_flat;
	logic [7:0] status_byte;
	logic spi_mode, hold_done, sample_now, frame_end, wr_hit;
	logic [6:0] wr_addr_c, wr_off;
	logic sda_oe_r, mode_r, ready_r;
	logic [1:0] rate_r, asel_r;

	// ---------------- host_clk domain ----------------
	logic [3:0] bit_cnt_r;
	logic [7:0] sh_r, cmd_r, rd_sh_r, rd_byte;
	logic rd_phase_r, wr_valid_r, so_bit_r, so_oe_r;
	logic [14:0] wr_word_r;
	logic lmode_s1_r, lmode_s2_r;
	logic [31:0] lstat_s1_r, lstat_s2_r;
	logic [6:0] rd_addr_c, rd_off;

	role_mem_if mem_port ();

	gpio_role_mem u_mem (
		.clk(clk),
		.nrst(nrst),
		.port(mem_port.mem)
	);

	// strap period then run; counter only runs during the strap period
	assign hold_done = (cnt_r == `STRAP_CNT_W'(STRAP_HOLD_CYCLES - 1));
	assign sample_now = (phase_r == ST_STRAP) && (cnt_r == `STRAP_SAMPLE_CYC);

	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			ST_STRAP: phase_nxt = hold_done ? ST_RUN : ST_STRAP;
			ST_RUN: phase_nxt = ST_RUN;
			default: phase_nxt = ST_STRAP;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_r <= ST_STRAP;
			cnt_r <= '0;
		end else begin
			phase_r <= phase_nxt;
			if (phase_r == ST_STRAP)
				cnt_r <= cnt_r + `STRAP_CNT_W'(1);
		end
	end

	// pin synchronisers: first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!nrst) begin
			gpio_s1_r <= 12'h000;
			gpio_s2_r <= 12'h000;
			pin_s1_r <= 2'h3;
			pin_s2_r <= 2'h3;
			i2c_s1_r <= 2'h3;
			i2c_s2_r <= 2'h3;
		end else begin
			gpio_s1_r <= gpio_in;
			gpio_s2_r <= gpio_s1_r;
			pin_s1_r <= {host_serial_out_addr_sel_hi_in,
				host_select_addr_sel_lo_n};
			pin_s2_r <= pin_s1_r;
			i2c_s1_r <= {scl_in, host_serial_in};
			i2c_s2_r <= i2c_s1_r;
		end
	end

	// RULE13 straps caught once
	// sampled after the sync chain fills, never re-taken until reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mode_r <= 1'b0;
			rate_r <= 2'h0;
		end else if (sample_now) begin
			// RULE3 mode from pin
			mode_r <= (gpio_s2_r[`GPIO_MODE_PIN] == `I2C_STRAP_LEVEL);
			// RULE4 rate from pins
			rate_r <= {gpio_s2_r[`GPIO_RATE_HI_PIN],
				gpio_s2_r[`GPIO_RATE_LO_PIN]};
		end
	end

	assign spi_mode = ~mode_r;

	// RULE2 status change flag
	// a change in the clearing cycle still sets the flag
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stat_prev_r <= dev_status;
			irq_r <= 1'b0;
		end else begin
			stat_prev_r <= dev_status;
			irq_r <= (dev_status != stat_prev_r) || (irq_r && !irq_clear);
		end
	end

	// roles are mirrored from the memory by a rolling scan
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scan_r <= 4'h0;
			scan_d_r <= 4'h0;
		end else begin
			scan_r <= (scan_r == 4'(`GPIO_COUNT - 1)) ? 4'h0 : scan_r + 4'h1;
			scan_d_r <= scan_r;
		end
	end

	// write frames cross when chip select rises; the word then stands still
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_s3_r <= 1'b1;
			wv_s1_r <= 1'b0;
			wv_s2_r <= 1'b0;
		end else begin
			cs_s1_r <= host_select_addr_sel_lo_n;
			cs_s2_r <= cs_s1_r;
			cs_s3_r <= cs_s2_r;
			wv_s1_r <= wr_valid_r;
			wv_s2_r <= wv_s1_r;
		end
	end

	assign frame_end = cs_s2_r && !cs_s3_r;
	assign wr_addr_c = wr_word_r[14:8];
	assign wr_off = wr_addr_c - `CFG_BASE_ADDR;
	// RULE8 write data stored
	assign wr_hit = frame_end && wv_s2_r && spi_mode &&
		(wr_addr_c >= `CFG_BASE_ADDR) && (wr_addr_c <= `CFG_LAST_ADDR);

	assign mem_port.wr_en = wr_hit;
	assign mem_port.wr_addr = wr_off[3:0];
	assign mem_port.wr_data = wr_word_r[1:0];
	assign mem_port.rd_addr = scan_r;

	assign status_byte = {ready_r, 4'h0, mode_r, rate_r};

	genvar i;
	generate
		for (i = 0; i < `GPIO_COUNT; i = i + 1) begin : g_pin
			logic drive;
			logic level;
			// RULE1 role sets pin use
			assign drive = ready_r && (role_r[i] != ROLE_IN);
			// RULE2 interrupt role drives flag
			assign level = (role_r[i] == ROLE_IRQ) ? irq_r : proc_gpio_out[i];
			assign role_flat[2*i+1:2*i] = role_r[i];
			always_ff @(posedge clk) begin
				if (!nrst) begin
					role_r[i] <= `ROLE_RST;
					gpio_oe[i] <= 1'b0;
					gpio_out[i] <= 1'b0;
				end else begin
					if (scan_d_r == 4'(i))
						role_r[i] <= mem_port.rd_data;
					// RULE5 strap pins left free
					// RULE6 pins 4, 5 not driven
					gpio_oe[i] <= drive;
					gpio_out[i] <= level;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ready_r <= 1'b0;
			sda_oe_r <= 1'b0;
			asel_r <= 2'h0;
			proc_gpio_in <= 12'h000;
			scl_sampled <= 1'b1;
			sda_sampled <= 1'b1;
		end else begin
			// RULE12 ready after hold time
			ready_r <= ready_r || hold_done;
			// RULE8 i2c data line
			sda_oe_r <= mode_r && ready_r && sda_pull_low;
			// RULE10 output pin read as address bit
			// RULE11 select pin read as address bit
			asel_r <= mode_r ? pin_s2_r : 2'h0;
			proc_gpio_in <= gpio_s2_r;
			// RULE7 i2c clock line
			scl_sampled <= i2c_s2_r[1];
			sda_sampled <= i2c_s2_r[0];
		end
	end

	assign host_mode = host_mode_t'(mode_r);
	assign clk_rate_sel = rate_r;
	assign regs_ready = ready_r;
	assign irq_pending = irq_r;
	assign i2c_addr_sel = asel_r;
	assign host_serial_out_addr_sel_hi_oe = so_oe_r;
	assign host_serial_in_oe = sda_oe_r;
	assign host_serial_in_out = 1'b0;

	// ---------------- link side on host_clk ----------------
	// mode and read values are quasi-static levels, synced bit by bit
	always_ff @(posedge host_clk) begin
		lmode_s1_r <= mode_r;
		lmode_s2_r <= lmode_s1_r;
		lstat_s1_r <= {status_byte, role_flat};
		lstat_s2_r <= lstat_s1_r;
	end

	assign rd_addr_c = {sh_r[5:0], host_serial_in};
	assign rd_off = rd_addr_c - `CFG_BASE_ADDR;
	assign rd_byte = (rd_addr_c == `STATUS_ADDR) ? lstat_s2_r[31:24] :
		((rd_addr_c >= `CFG_BASE_ADDR) && (rd_addr_c <= `CFG_LAST_ADDR)) ?
		{6'h00, lstat_s2_r[{rd_off[3:0], 1'b0} +: 2]} : 8'h00;

	// RULE7 spi clock input
	// RULE11 chip select frames
	// a raised select clears the count at once, so a cut frame is forgotten
	always_ff @(posedge host_clk or
		posedge host_select_addr_sel_lo_n) begin
		if (host_select_addr_sel_lo_n)
			bit_cnt_r <= 4'h0;
		else if (lmode_s2_r)
			bit_cnt_r <= 4'h0;
		else
			bit_cnt_r <= bit_cnt_r + 4'h1;
	end

	// RULE9 read data only
	// enable on the link clock: a clk-side copy would trail the first bit
	always_ff @(posedge host_clk or
		posedge host_select_addr_sel_lo_n) begin
		if (host_select_addr_sel_lo_n)
			so_oe_r <= 1'b0;
		else if (bit_cnt_r == `SPI_CMD_LAST)
			so_oe_r <= !lmode_s2_r && sh_r[`SPI_READ_BIT-1];
		else if (bit_cnt_r == 4'h0)
			so_oe_r <= 1'b0;
	end

	always_ff @(posedge host_clk) begin
		if (!host_select_addr_sel_lo_n) begin
			// RULE8 command, address, data in
			sh_r <= {sh_r[6:0], host_serial_in};
			if (bit_cnt_r == 4'h0) begin
				rd_phase_r <= 1'b0;
				wr_valid_r <= 1'b0;
			end
			if (bit_cnt_r == `SPI_CMD_LAST) begin
				cmd_r <= {sh_r[6:0], host_serial_in};
				rd_phase_r <= sh_r[`SPI_READ_BIT-1];
			end
			if (bit_cnt_r == `SPI_FRAME_LAST) begin
				rd_phase_r <= 1'b0;
				wr_valid_r <= ~cmd_r[`SPI_READ_BIT];
				wr_word_r <= {cmd_r[6:0], sh_r[6:0], host_serial_in};
			end
		end
	end

	// RULE9 read bits shifted out
	// the read byte is taken on the last command edge, one bit later
	always_ff @(posedge host_clk) begin
		if (host_select_addr_sel_lo_n) begin
			so_bit_r <= 1'b0;
		end else if (bit_cnt_r == `SPI_CMD_LAST) begin
			rd_sh_r <= rd_byte;
		end else if (rd_phase_r && bit_cnt_r > `SPI_CMD_LAST) begin
			so_bit_r <= rd_sh_r[7];
			rd_sh_r <= {rd_sh_r[6:0], 1'b0};
		end
	end

	assign host_serial_out_addr_sel_hi_out = so_bit_r;
endmodule : reset_strap_host_pin_select

// ---- verif/reset_strap_host_pin_select_assertions.sv ----
// port assertions for the strap and host pin block
// assumes one clk domain; bound to every instance of the block
`timescale 1ns/1ps
module reset_strap_host_pin_select_chk #(
	parameter int unsigned STRAP_HOLD_CYCLES = 40
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [11:0] gpio_oe,
	input wire logic [7:0] dev_status,
	input wire logic irq_clear,
	input wire logic irq_pending,
	input wire logic host_select_addr_sel_lo_n,
	input wire logic host_serial_in_oe,
	input wire logic host_serial_out_addr_sel_hi_oe,
	input wire logic sda_pull_low,
	input wire strap_pkg::host_mode_t host_mode,
	input wire strap_pkg::rate_sel_t clk_rate_sel,
	input wire logic [1:0] i2c_addr_sel,
	input wire logic regs_ready
);
	import strap_pkg::*;
	int unsigned cnt_r;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// saturating so a long run cannot wrap it
	always_ff @(posedge clk) begin
		if (!nrst)
			cnt_r <= 0;
		else if (cnt_r < STRAP_HOLD_CYCLES + 2)
			cnt_r <= cnt_r + 1;
	end
	a_ready_time: assert property (
		$rose(regs_ready) |-> cnt_r >= STRAP_HOLD_CYCLES &&
		cnt_r <= STRAP_HOLD_CYCLES + 1) else $error("ready off time");
	a_ready_late: assert property (
		cnt_r > STRAP_HOLD_CYCLES + 1 |-> regs_ready)
		else $error("ready late");
	a_strap_held: assert property (
		regs_ready && $past(regs_ready) |->
		$stable(host_mode) && $stable(clk_rate_sel))
		else $error("strap value moved");
	a_no_drive_early: assert property (
		!regs_ready |-> gpio_oe == 12'h000) else $error("early drive");
	a_so_i2c_off: assert property (
		host_mode == HOST_I2C |-> !host_serial_out_addr_sel_hi_oe)
		else $error("so driven in i2c");
	a_so_frame_off: assert property (
		host_select_addr_sel_lo_n [*8] |-> !host_serial_out_addr_sel_hi_oe)
		else $error("so driven outside frame");
	a_sda_route: assert property (
		host_mode == HOST_I2C && regs_ready |=>
		host_serial_in_oe == $past(sda_pull_low)) else $error("sda route");
	a_asel_spi: assert property (
		host_mode == HOST_SPI |-> i2c_addr_sel == 2'h0)
		else $error("addr select in spi");
	a_irq_set: assert property (
		$past(nrst) && dev_status != $past(dev_status) |=> irq_pending)
		else $error("irq not set");
	a_irq_sticky: assert property (
		irq_pending && !irq_clear |=> irq_pending) else $error("irq lost");
endmodule : reset_strap_host_pin_select_chk
bind reset_strap_host_pin_select reset_strap_host_pin_select_chk #(
	.STRAP_HOLD_CYCLES(STRAP_HOLD_CYCLES)
) i_chk (
	.clk(clk), .nrst(nrst), .gpio_oe(gpio_oe), .dev_status(dev_status),
	.irq_clear(irq_clear), .irq_pending(irq_pending),
	.host_select_addr_sel_lo_n(host_select_addr_sel_lo_n),
	.host_serial_in_oe(host_serial_in_oe),
	.host_serial_out_addr_sel_hi_oe(host_serial_out_addr_sel_hi_oe),
	.sda_pull_low(sda_pull_low), .host_mode(host_mode),
	.clk_rate_sel(clk_rate_sel), .i2c_addr_sel(i2c_addr_sel),
	.regs_ready(regs_ready)
);

// ---- verif/strap_board_model.sv ----
// board straps and pull resistors on the general purpose pins
// assumes the bench drops strap_hold once the hold time has run out
`timescale 1ns/1ps
module strap_board_model (
	input wire logic strap_hold,
	input wire logic [11:0] strap_val,
	input wire logic [11:0] gpio_out,
	input wire logic [11:0] gpio_oe,
	output logic [11:0] gpio_in
);
	logic [11:0] far;
	assign far = strap_hold ? (strap_val & 12'hFCF) : 12'hFC0;
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & far);
endmodule : strap_board_model

// ---- verif/reset_strap_host_pin_select_test.sv ----
// bench for the strap and host pin block: straps, spi frames, i2c pins
// assumes the hold time is shortened to HOLD cycles
`timescale 1ns/1ps
module reset_strap_host_pin_select_test;
	import strap_pkg::*;
	localparam int unsigned HOLD = 40;
	logic clk = 0, nrst = 0, host_clk = 0, hold = 1, irq_clear = 0;
	logic cs_n = 0, si = 1, ahi = 0, scl = 1, pull = 0, wr = 0, seen = 0;
	logic [11:0] strap = 12'h002, gpio_in, gpio_out, gpio_oe, pgo = 0, pgi;
	logic [7:0] stat = 0, rx;
	logic irq, si_out, si_oe, so_out, so_oe, scl_s, sda_s, ready, so_pin;
	logic [1:0] asel;
	host_mode_t mode;
	rate_sel_t rate;
	int n_errors = 0, n_tests = 0, cyc = 0;
	// in spi mode an undriven output pin shows a changed level, not the last bit
	assign so_pin = so_oe ? so_out : (mode == HOST_I2C ? ahi : ~so_out);
	always #25 clk = ~clk;
	reset_strap_host_pin_select #(.STRAP_HOLD_CYCLES(HOLD))
		i_reset_strap_host_pin_select (
		.clk(clk), .nrst(nrst), .host_clk(host_clk), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .proc_gpio_out(pgo),
		.proc_gpio_in(pgi), .dev_status(stat), .irq_clear(irq_clear),
		.irq_pending(irq), .host_select_addr_sel_lo_n(cs_n),
		.host_serial_in(si_oe ? 1'b0 : si), .host_serial_in_out(si_out),
		.host_serial_in_oe(si_oe), .host_serial_out_addr_sel_hi_in(so_pin),
		.host_serial_out_addr_sel_hi_out(so_out),
		.host_serial_out_addr_sel_hi_oe(so_oe), .scl_in(scl),
		.scl_sampled(scl_s), .sda_sampled(sda_s), .sda_pull_low(pull),
		.host_mode(mode), .clk_rate_sel(rate), .i2c_addr_sel(asel),
		.regs_ready(ready));
	strap_board_model i_strap_board_model (.strap_hold(hold),
		.strap_val(strap), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.gpio_in(gpio_in));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wr && so_oe)
			seen <= 1;
		if (cyc == 5000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic boot(input logic [11:0] s);
		@(posedge clk);
		nrst <= 0;
		// the first rise of select clears the link counter
		cs_n <= 1;
		hold <= 1;
		strap <= s;
		repeat (5) @(posedge clk);
		nrst <= 1;
		while (ready !== 1'b1) @(posedge clk);
		hold <= 0;
		repeat (8) @(posedge clk);
	endtask : boot
	task automatic spi(input logic [15:0] tx, output logic [7:0] d);
		@(posedge clk);
		cs_n <= 0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 16; i++) begin
			si = tx[15 - i];
			#32 host_clk = 1;
			#30 if (i > 7) d = {d[6:0], so_pin};
			#2 host_clk = 0;
		end
		@(posedge clk);
		cs_n <= 1;
		repeat (24) @(posedge clk);
	endtask : spi
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		boot(12'h002);
		chk(12'(mode), 12'(HOST_SPI));
		chk(12'(rate), 12'h002);
		chk(pgi & 12'h204, 12'h200);
		spi(16'h8000, rx);
		chk(12'(rx), 12'h082);
		$display("test straps and status done");
		wr = 1;
		spi(16'h0701, rx);
		wr = 0;
		chk(gpio_oe, 12'h040);
		chk(12'(pgi[6]), 12'h000);
		chk(12'(seen), 12'h000);
		@(posedge clk);
		pgo <= 12'h040;
		repeat (20) @(posedge clk);
		chk(gpio_out & 12'h040, 12'h040);
		spi(16'h8700, rx);
		chk(12'(rx), 12'h001);
		spi(16'hA000, rx);
		chk(12'(rx), 12'h000);
		$display("test roles done");
		spi(16'h0902, rx);
		@(posedge clk);
		stat <= 8'h10;
		repeat (20) @(posedge clk);
		chk(12'(irq), 12'h001);
		chk(gpio_oe & gpio_out & 12'h100, 12'h100);
		irq_clear <= 1;
		@(posedge clk);
		irq_clear <= 0;
		repeat (20) @(posedge clk);
		chk(12'(irq), 12'h000);
		chk(gpio_out & 12'h100, 12'h000);
		$display("test irq done");
		boot(12'h009);
		chk(12'(mode), 12'(HOST_I2C));
		chk(12'(rate), 12'h001);
		@(posedge clk);
		ahi <= 1;
		cs_n <= 0;
		pull <= 1;
		scl <= 0;
		repeat (6) @(posedge clk);
		chk(12'(asel), 12'h002);
		chk(12'(so_oe), 12'h000);
		chk(12'(si_oe), 12'h001);
		chk(12'({scl_s, sda_s}), 12'h000);
		$display("test i2c pins done");
		end_sim();
	end
endmodule : reset_strap_host_pin_select_test
